// ==== hw/ldpa_pkg.sv ====
// constants for the link diagnostic and phy access register bank
package ldpa_pkg;
	// ----------------------------------------
	// host address map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_DIAG = 8'h20; // diagnostic control
	localparam logic [7:0] OFF_PHY = 8'h24; // phy register access
	localparam logic [7:0] OFF_ATF = 8'h30; // async tx fifo status
	localparam logic [7:0] OFF_RAM_WIN = 8'h80; // fifo push / ram test window
	localparam logic [7:0] OFF_ATF_HEAD = 8'h84; // fifo push with start marker

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [31:0] RST_DIAG = 32'h0000_0000;
	localparam logic [31:0] RST_PHY = 32'h0000_0000;
	localparam logic [31:0] RST_ATF = 32'h0000_0000;

	// ----------------------------------------
	// diagnostic fields
	// ----------------------------------------
	localparam int DIAG_SNOOP = 0; // snoop_enable
	localparam int DIAG_UNLOCK = 4; // register_write_unlock_bit
	localparam logic [31:0] DIAG_OPEN_MASK = 32'h0000_0011; // always writable
	localparam logic [31:0] ALL_MASK = 32'hFFFF_FFFF;

	// ----------------------------------------
	// phy access fields
	// ----------------------------------------
	localparam int PHY_RD = 0; // phy_read_request
	localparam int PHY_WR = 1; // phy_write_request
	localparam int PHY_AD_LSB = 4; // phy_request_address
	localparam int PHY_WD_LSB = 8; // phy_request_write_data
	localparam int PHY_RXAD_LSB = 20; // phy_reply_address
	localparam int PHY_RXD_LSB = 24; // phy_reply_data

	// ----------------------------------------
	// fifo status fields
	// ----------------------------------------
	localparam int ATF_FULL = 0;
	localparam int ATF_EMPTY = 1;
	localparam int ATF_CONTROL_BIT_MISMATCH = 2; // control_bit_mismatch
	localparam int ATF_CLR = 3; // test_pointer_clear
	localparam int ATF_CTRL = 4; // expected control bit
	localparam int ATF_MODE = 5; // fifo_ram_test_mode
	localparam int ATF_PTR_LSB = 6; // ram_test_pointer

	// ----------------------------------------
	// fifo geometry
	// ----------------------------------------
	localparam int FIFO_W = 33; // data plus packet_start_marker
	localparam int FIFO_AW = 9;
	localparam int FIFO_DEPTH = 512;
	localparam logic [9:0] FIFO_FULL_CNT = 10'h200;
endpackage

// ==== hw/ldpa_fifo_ram.sv ====
// flip-flop storage shared by the fifo and the ram test window
`timescale 1ns/1ps
`default_nettype none
module ldpa_fifo_ram (
	input wire logic mclk, // core clock
	input wire logic we, // write strobe
	input wire logic [ldpa_pkg::FIFO_AW-1:0] waddr, // write index
	input wire logic [ldpa_pkg::FIFO_W-1:0] wdata, // write word
	input wire logic [ldpa_pkg::FIFO_AW-1:0] raddr, // read index
	output logic [ldpa_pkg::FIFO_W-1:0] rdata // read word, combinational
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [ldpa_pkg::FIFO_W-1:0] mem_reg [ldpa_pkg::FIFO_DEPTH]; // no reset: contents undefined

	// write port
	always_ff @(posedge mclk) begin
		if (we) begin
			mem_reg[waddr] <= wdata;
		end
	end

	// read port, same-cycle so host reads can be registered once
	assign rdata = mem_reg[raddr];
endmodule // ldpa_fifo_ram
`default_nettype wire

// ==== hw/ldpa_regs.sv ====
// diagnostic, phy access and async tx fifo status registers
`timescale 1ns/1ps
`default_nettype none
module ldpa_regs (
	input wire logic mclk, // core clock, 25 MHz
	input wire logic rstn, // async reset, active low
	input wire logic host_sel, // host access strobe
	input wire logic host_wr, // host write
	input wire logic host_rd, // host read
	input wire logic [7:0] host_addr, // host byte address
	input wire logic [31:0] host_wdata, // host write data
	output logic [31:0] host_rdata, // read data
	output logic host_rvalid, // read data valid pulse
	output logic phy_req_valid, // request to phy interface
	output logic phy_req_write, // 1 write, 0 read
	output logic [3:0] phy_req_addr, // phy register address
	output logic [7:0] phy_req_data, // phy write data
	input wire logic phy_req_accept, // phy interface took request
	input wire logic phy_reply_valid, // new phy register info
	input wire logic [3:0] phy_reply_addr, // source register
	input wire logic [7:0] phy_reply_data, // returned byte
	output logic phy_reg_reply_irq, // reply interrupt pulse
	output logic snoop_enable, // receiver takes all packets
	output logic register_write_unlock, // read-only fields open
	output logic fifo_ram_test_mode, // other fifos halt
	input wire logic atf_pop, // link core pops a word
	output logic [32:0] atf_pop_data, // popped word
	output logic atf_pop_valid, // popped word valid pulse
	output logic atf_empty // fifo empty flag
);
	// ----------------------------------------
	// decode helper
	// ----------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [31:0] diag_reg; // diagnostic control
	logic phy_rd_reg; // pending read request
	logic phy_wr_reg; // pending write request
	logic [3:0] phy_ad_reg; // request address
	logic [7:0] phy_wd_reg; // request write data
	logic [3:0] phy_rxad_reg; // reply address
	logic [7:0] phy_rxd_reg; // reply data
	logic req_valid_reg; // request on phy interface
	logic req_write_reg; // request kind
	logic [3:0] req_addr_reg; // request address held
	logic [7:0] req_data_reg; // request data held
	logic irq_reg; // reply interrupt pulse
	logic control_bit_mismatch_reg; // control_bit_mismatch
	logic clr_reg; // test_pointer_clear pending
	logic ctrl_reg; // expected control bit
	logic mode_reg; // fifo_ram_test_mode
	logic [8:0] ptr_reg; // ram_test_pointer
	logic [8:0] wr_ptr_reg; // fifo write index
	logic [8:0] rd_ptr_reg; // fifo read index
	logic [9:0] cnt_reg; // fifo fill count
	logic [9:0] cnt_next; // next fill count
	logic full_reg; // fifo full
	logic empty_reg; // fifo empty
	logic [32:0] pop_data_reg; // popped word
	logic pop_valid_reg; // popped word valid
	logic [31:0] rdata_reg; // host read data
	logic rvalid_reg; // host read valid

	// ----------------------------------------
	// access decode
	// ----------------------------------------
	logic wr_any; // host write this cycle
	logic rd_any; // host read this cycle
	logic unlocked; // write unlock active
	logic wr_diag; // write to diagnostic
	logic wr_phy; // write to phy access
	logic wr_atf; // write to fifo status
	logic test_acc; // ram test window access
	logic test_rd; // ram test window read
	logic [8:0] tst_addr; // ram index this access
	logic push; // accepted fifo push
	logic pop; // accepted fifo pop
	logic ram_we; // storage write
	logic [8:0] ram_waddr; // storage write index
	logic [32:0] ram_wdata; // storage write word
	logic [8:0] ram_raddr; // storage read index
	logic [32:0] ram_rdata; // storage read word
	logic mismatch; // control bit compare failed
	logic req_done; // phy took request

	assign wr_any = host_sel & host_wr;
	assign rd_any = host_sel & host_rd & ~host_wr; // write wins a double strobe
	assign unlocked = diag_reg[ldpa_pkg::DIAG_UNLOCK];
	assign wr_diag = wr_any & hit(host_addr, ldpa_pkg::OFF_DIAG);
	assign wr_phy = wr_any & hit(host_addr, ldpa_pkg::OFF_PHY);
	assign wr_atf = wr_any & hit(host_addr, ldpa_pkg::OFF_ATF);
	// test mode turns the push window into a plain ram port
	assign test_acc = mode_reg & (wr_any | rd_any) & hit(host_addr, ldpa_pkg::OFF_RAM_WIN);
	assign test_rd = test_acc & rd_any;
	// pending clear forces this access to location zero
	assign tst_addr = clr_reg ? 9'h000 : ptr_reg;
	// full discards the push, test mode blocks both ends
	assign push = wr_any & ~mode_reg & ~full_reg & (hit(host_addr, ldpa_pkg::OFF_RAM_WIN) |
		hit(host_addr, ldpa_pkg::OFF_ATF_HEAD));
	assign pop = atf_pop & ~empty_reg & ~mode_reg;
	assign ram_we = (test_acc & wr_any) | push;
	assign ram_waddr = mode_reg ? tst_addr : wr_ptr_reg;
	// top bit is the start marker, or the expected bit in test mode
	assign ram_wdata = mode_reg ? {ctrl_reg, host_wdata} :
		{hit(host_addr, ldpa_pkg::OFF_ATF_HEAD), host_wdata};
	assign ram_raddr = mode_reg ? tst_addr : rd_ptr_reg;
	assign mismatch = test_rd & (ram_rdata[32] != ctrl_reg);
	assign req_done = req_valid_reg & phy_req_accept;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	ldpa_fifo_ram u_ram (
		.mclk(mclk),
		.we(ram_we),
		.waddr(ram_waddr),
		.wdata(ram_wdata),
		.raddr(ram_raddr),
		.rdata(ram_rdata)
	);

	// ----------------------------------------
	// diagnostic control
	// ----------------------------------------
	// only snoop and unlock move while locked
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			diag_reg <= ldpa_pkg::RST_DIAG;
		end else if (wr_diag) begin
			if (unlocked) begin
				diag_reg <= host_wdata;
			end else begin
				diag_reg <= (diag_reg & ~ldpa_pkg::DIAG_OPEN_MASK) |
					(host_wdata & ldpa_pkg::DIAG_OPEN_MASK);
			end
		end
	end

	// ----------------------------------------
	// phy access: host half
	// ----------------------------------------
	// host write beats the hardware clear, so a fresh request survives
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phy_rd_reg <= 1'b0;
			phy_wr_reg <= 1'b0;
			phy_ad_reg <= 4'h0;
			phy_wd_reg <= 8'h00;
		end else if (wr_phy) begin
			phy_rd_reg <= host_wdata[ldpa_pkg::PHY_RD];
			phy_wr_reg <= host_wdata[ldpa_pkg::PHY_WR];
			phy_ad_reg <= host_wdata[ldpa_pkg::PHY_AD_LSB +: 4];
			phy_wd_reg <= host_wdata[ldpa_pkg::PHY_WD_LSB +: 8];
		end else if (req_done) begin
			if (req_write_reg) begin
				phy_wr_reg <= 1'b0;
			end else begin
				phy_rd_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// phy access: request launcher
	// ----------------------------------------
	// read goes first when both are pending; one request in flight
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			req_valid_reg <= 1'b0;
			req_write_reg <= 1'b0;
			req_addr_reg <= 4'h0;
			req_data_reg <= 8'h00;
		end else if (req_valid_reg) begin
			if (phy_req_accept) begin
				req_valid_reg <= 1'b0;
			end
		end else if (phy_rd_reg) begin
			req_valid_reg <= 1'b1;
			req_write_reg <= 1'b0;
			req_addr_reg <= phy_ad_reg;
		end else if (phy_wr_reg) begin
			req_valid_reg <= 1'b1;
			req_write_reg <= 1'b1;
			req_addr_reg <= phy_ad_reg;
			req_data_reg <= phy_wd_reg;
		end
	end

	// ----------------------------------------
	// phy access: reply half
	// ----------------------------------------
	// a reply wins over an unlocked host write in the same cycle
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			phy_rxad_reg <= 4'h0;
			phy_rxd_reg <= 8'h00;
		end else if (phy_reply_valid) begin
			phy_rxad_reg <= phy_reply_addr;
			phy_rxd_reg <= phy_reply_data;
		end else if (wr_phy && unlocked) begin
			phy_rxad_reg <= host_wdata[ldpa_pkg::PHY_RXAD_LSB +: 4];
			phy_rxd_reg <= host_wdata[ldpa_pkg::PHY_RXD_LSB +: 8];
		end
	end

	// reply interrupt pulse toward the interrupt register
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= phy_reply_valid;
		end
	end

	// ----------------------------------------
	// fifo status control bits
	// ----------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctrl_reg <= 1'b0;
			mode_reg <= 1'b0;
			clr_reg <= 1'b0;
			ptr_reg <= 9'h000;
		end else if (wr_atf) begin
			ctrl_reg <= host_wdata[ldpa_pkg::ATF_CTRL];
			mode_reg <= host_wdata[ldpa_pkg::ATF_MODE];
			clr_reg <= host_wdata[ldpa_pkg::ATF_CLR];
			if (unlocked) begin
				ptr_reg <= host_wdata[ldpa_pkg::ATF_PTR_LSB +: 9];
			end
		end else if (test_acc) begin
			ptr_reg <= 9'(tst_addr + 9'h001);
			clr_reg <= 1'b0;
		end
	end

	// mismatch flag: a set on a test read wins over any clear
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			control_bit_mismatch_reg <= 1'b0;
		end else if (mismatch) begin
			control_bit_mismatch_reg <= 1'b1;
		end else if (wr_atf && (host_wdata[ldpa_pkg::ATF_CLR] || !host_wdata[ldpa_pkg::ATF_MODE])) begin
			control_bit_mismatch_reg <= 1'b0;
		end else if (test_acc && clr_reg) begin
			control_bit_mismatch_reg <= 1'b0;
		end else if (wr_atf && unlocked) begin
			control_bit_mismatch_reg <= host_wdata[ldpa_pkg::ATF_CONTROL_BIT_MISMATCH];
		end
	end

	// ----------------------------------------
	// fifo pointers and flags
	// ----------------------------------------
	always_comb begin
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = 10'(cnt_reg + 10'h001);
		end else if (pop && !push) begin
			cnt_next = 10'(cnt_reg - 10'h001);
		end
	end

	// pointers freeze while the storage is a ram
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr_reg <= 9'h000;
			rd_ptr_reg <= 9'h000;
			cnt_reg <= 10'h000;
			full_reg <= 1'b0;
			empty_reg <= 1'b1;
		end else begin
			if (push) begin
				wr_ptr_reg <= 9'(wr_ptr_reg + 9'h001);
			end
			if (pop) begin
				rd_ptr_reg <= 9'(rd_ptr_reg + 9'h001);
			end
			cnt_reg <= cnt_next;
			full_reg <= (cnt_next == ldpa_pkg::FIFO_FULL_CNT);
			empty_reg <= (cnt_next == 10'h000);
		end
	end

	// popped word toward the transmitter
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pop_valid_reg <= 1'b0;
			pop_data_reg <= 33'h0_0000_0000;
		end else begin
			pop_valid_reg <= pop;
			if (pop) begin
				pop_data_reg <= ram_rdata;
			end
		end
	end

	// ----------------------------------------
	// host read mux
	// ----------------------------------------
	// unmapped addresses, and the push window outside test mode, read zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			rvalid_reg <= rd_any;
			if (rd_any) begin
				if (hit(host_addr, ldpa_pkg::OFF_DIAG)) begin
					rdata_reg <= diag_reg;
				end else if (hit(host_addr, ldpa_pkg::OFF_PHY)) begin
					rdata_reg <= {phy_rxd_reg, phy_rxad_reg, 4'h0, phy_wd_reg,
						phy_ad_reg, 2'h0, phy_wr_reg, phy_rd_reg};
				end else if (hit(host_addr, ldpa_pkg::OFF_ATF)) begin
					rdata_reg <= {17'h0_0000, ptr_reg, mode_reg, ctrl_reg, clr_reg,
						control_bit_mismatch_reg, empty_reg, full_reg};
				end else if (test_rd) begin
					rdata_reg <= ram_rdata[31:0];
				end else begin
					rdata_reg <= 32'h0000_0000;
				end
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign host_rdata = rdata_reg;
	assign host_rvalid = rvalid_reg;
	assign phy_req_valid = req_valid_reg;
	assign phy_req_write = req_write_reg;
	assign phy_req_addr = req_addr_reg;
	assign phy_req_data = req_data_reg;
	assign phy_reg_reply_irq = irq_reg;
	assign snoop_enable = diag_reg[ldpa_pkg::DIAG_SNOOP];
	assign register_write_unlock = diag_reg[ldpa_pkg::DIAG_UNLOCK];
	assign fifo_ram_test_mode = mode_reg;
	assign atf_pop_data = pop_data_reg;
	assign atf_pop_valid = pop_valid_reg;
	assign atf_empty = empty_reg;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	chk_diag_locked: assert property (
		@(posedge mclk) disable iff (!rstn)
		wr_diag && !unlocked |=> diag_reg[31:5] == $past(diag_reg[31:5]))
		else $error("locked diagnostic bits changed");
	chk_snoop_follows: assert property (
		@(posedge mclk) disable iff (!rstn)
		wr_diag |=> snoop_enable == $past(host_wdata[0]))
		else $error("snoop enable not written");
	chk_phy_read_issue: assert property (
		@(posedge mclk) disable iff (!rstn)
		!req_valid_reg && phy_rd_reg && !wr_phy |=> phy_req_valid && !phy_req_write)
		else $error("phy read request not issued");
	chk_phy_req_clear: assert property (
		@(posedge mclk) disable iff (!rstn)
		req_done && req_write_reg && !wr_phy |=> !phy_wr_reg && !phy_req_valid)
		else $error("phy write request not cleared");
	chk_reply_capture: assert property (
		@(posedge mclk) disable iff (!rstn)
		phy_reply_valid |=> phy_rxad_reg == $past(phy_reply_addr) &&
			phy_rxd_reg == $past(phy_reply_data) && phy_reg_reply_irq)
		else $error("phy reply not captured");
	chk_full_drop: assert property (
		@(posedge mclk) disable iff (!rstn)
		full_reg && wr_any && !mode_reg |=> $stable(wr_ptr_reg))
		else $error("write accepted while full");
	chk_empty_flag: assert property (
		@(posedge mclk) disable iff (!rstn)
		empty_reg == (cnt_reg == 10'h000) && !(empty_reg && full_reg))
		else $error("empty flag wrong");
	chk_ptr_advance: assert property (
		@(posedge mclk) disable iff (!rstn)
		test_acc && !clr_reg |=> ptr_reg == 9'($past(ptr_reg) + 9'h001))
		else $error("test pointer did not advance");
	chk_ptr_clear: assert property (
		@(posedge mclk) disable iff (!rstn)
		test_acc && clr_reg |=> ptr_reg == 9'h001 && !clr_reg)
		else $error("pointer clear did not hit location zero");
	chk_mismatch_set: assert property (
		@(posedge mclk) disable iff (!rstn)
		mismatch |=> control_bit_mismatch_reg [*1] ##0 rdata_reg == $past(ram_rdata[31:0]))
		else $error("mismatch flag not set");
	chk_mismatch_clear: assert property (
		@(posedge mclk) disable iff (!rstn)
		wr_atf && host_wdata[ldpa_pkg::ATF_CLR] |=> !control_bit_mismatch_reg)
		else $error("mismatch flag not cleared");
	chk_test_no_pop: assert property (
		@(posedge mclk) disable iff (!rstn)
		mode_reg |=> !atf_pop_valid && $stable(rd_ptr_reg))
		else $error("fifo popped in test mode");
endmodule // ldpa_regs
`default_nettype wire

// ==== verif/ldpa_phy_model.sv ====
// behavioural phy interface partner for the register bank
`timescale 1ns/1ps
`default_nettype none
module ldpa_phy_model (
	input wire logic mclk, // core clock
	input wire logic rstn, // async reset, active low
	input wire logic slow, // hold off accept for four cycles
	input wire logic req_valid, // request pending
	input wire logic req_write, // 1 write, 0 read
	input wire logic [3:0] req_addr, // register address
	input wire logic [7:0] req_data, // write byte
	output logic accept, // request taken
	output logic reply_valid, // reply pulse
	output logic [3:0] reply_addr, // reply address
	output logic [7:0] reply_data, // reply byte
	output logic [3:0] wr_addr, // last written address
	output logic [7:0] wr_data // last written byte
);
	logic [2:0] wait_cnt; // cycles spent before accepting
	logic read_q; // accepted request was a read
	logic [3:0] addr_q; // address of accepted request
	// falling-edge drive so the core samples settled values
	always @(negedge mclk or negedge rstn) begin
		if (!rstn) begin
			{accept, reply_valid, reply_addr, reply_data, wr_addr, wr_data} <= '0;
			{wait_cnt, read_q, addr_q} <= '0;
		end else begin
			accept <= 1'b0;
			reply_valid <= 1'b0;
			read_q <= 1'b0;
			// idle reply lines toggle, so a stale capture shows up
			reply_addr <= ~reply_addr;
			reply_data <= ~reply_data;
			if (read_q) begin
				reply_valid <= 1'b1;
				reply_addr <= addr_q;
				reply_data <= {4'hA, addr_q};
			end
			// accept promptly or slowly, never twice for one request
			if (req_valid && !accept) begin
				if (wait_cnt >= (slow ? 3'd4 : 3'd0)) begin
					accept <= 1'b1;
					wait_cnt <= '0;
					read_q <= !req_write;
					addr_q <= req_addr;
					wr_addr <= req_write ? req_addr : wr_addr;
					wr_data <= req_write ? req_data : wr_data;
				end else begin
					wait_cnt <= wait_cnt + 3'd1;
				end
			end
		end
	end
endmodule // ldpa_phy_model
`default_nettype wire

// ==== verif/link_diag_phy_access_regs_bench.sv ====
// self-checking bench for the diagnostic and phy access register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module link_diag_phy_access_regs_bench;
	logic mclk, rstn, host_sel, host_wr, host_rd, atf_pop, slow; // bench controls
	logic [7:0] host_addr; // host byte address
	logic [31:0] host_wdata, host_rdata; // bus data
	logic host_rvalid, phy_req_valid, phy_req_write, phy_req_accept, phy_reply_valid;
	logic phy_reg_reply_irq, snoop_enable, register_write_unlock, fifo_ram_test_mode;
	logic atf_pop_valid, atf_empty; // fifo flags
	logic [3:0] phy_req_addr, phy_reply_addr, wr_addr; // phy addresses
	logic [7:0] phy_req_data, phy_reply_data, wr_data; // phy bytes
	logic [32:0] atf_pop_data; // popped word
	int failures, checks, cycles, i; // counters

	ldpa_regs dut (.mclk, .rstn, .host_sel, .host_wr, .host_rd, .host_addr, .host_wdata,
		.host_rdata, .host_rvalid, .phy_req_valid, .phy_req_write, .phy_req_addr,
		.phy_req_data, .phy_req_accept, .phy_reply_valid, .phy_reply_addr, .phy_reply_data,
		.phy_reg_reply_irq, .snoop_enable, .register_write_unlock, .fifo_ram_test_mode,
		.atf_pop, .atf_pop_data, .atf_pop_valid, .atf_empty);
	ldpa_phy_model phy (.mclk, .rstn, .slow, .req_valid(phy_req_valid),
		.req_write(phy_req_write), .req_addr(phy_req_addr), .req_data(phy_req_data),
		.accept(phy_req_accept), .reply_valid(phy_reply_valid), .reply_addr(phy_reply_addr),
		.reply_data(phy_reply_data), .wr_addr, .wr_data);

	// ----------------------------------------
	// clock, hang guard and verdict
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// a full fifo fill and drain takes about 2050 cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			summarize();
		end
	end
	task automatic summarize();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// ----------------------------------------
	// host and fifo access tasks
	// ----------------------------------------
	// one-cycle strobe, driven on the falling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(negedge mclk);
		{host_sel, host_wr, host_addr, host_wdata} = {2'b11, a, d};
		@(negedge mclk);
		{host_sel, host_wr} = 2'b00;
	endtask
	// read data stands one cycle after the strobe edge; mask hides free fields
	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFF_FFFF);
		@(negedge mclk);
		{host_sel, host_rd, host_addr} = {2'b11, a};
		@(negedge mclk);
		{host_sel, host_rd} = 2'b00;
		`CHK(host_rvalid, 1'b1)
		`CHK(host_rdata & m, e)
	endtask
	task automatic pop(input logic [32:0] e);
		@(negedge mclk);
		atf_pop = 1'b1;
		@(negedge mclk);
		atf_pop = 1'b0;
		`CHK(atf_pop_valid, 1'b1)
		`CHK(atf_pop_data, e)
	endtask
	// bounded wait for the reply interrupt pulse
	task automatic wait_irq();
		for (i = 0; i < 50 && phy_reg_reply_irq !== 1'b1; i++) @(negedge mclk);
		`CHK(phy_reg_reply_irq, 1'b1)
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{host_sel, host_wr, host_rd, atf_pop, slow, host_addr, host_wdata, rstn} = '0;
		repeat (4) @(negedge mclk);
		rstn = 1'b1;
		rdc(8'h20, 32'h0000_0000);
		rdc(8'h24, 32'h0000_0000);
		rdc(8'h30, 32'h0000_0002);
		rdc(8'h40, 32'h0000_0000);
		// locked writes only reach the two open bits
		wr(8'h20, 32'hFFFF_FFFF);
		rdc(8'h20, 32'h0000_0011);
		`CHK({snoop_enable, register_write_unlock}, 2'b11)
		wr(8'h20, 32'hFFFF_FFFF);
		rdc(8'h20, 32'hFFFF_FFFF);
		wr(8'h20, 32'h0000_0000);
		// slow phy read, then prompt phy write
		slow = 1'b1;
		wr(8'h24, 32'h0000_0051);
		wait_irq();
		rdc(8'h24, 32'hA550_0050);
		slow = 1'b0;
		wr(8'h24, 32'h0000_3C72);
		repeat (6) @(negedge mclk);
		`CHK({wr_addr, wr_data}, 12'h73C)
		rdc(8'h24, 32'hA550_3C70);
		// packet start marker, then fill until refused and drain
		wr(8'h84, 32'h1234_5678);
		rdc(8'h30, 32'h0000_0000);
		pop(33'h1_1234_5678);
		for (i = 0; i < 512; i++) wr(8'h80, 32'(i));
		rdc(8'h30, 32'h0000_0001);
		`CHK(atf_empty, 1'b0)
		wr(8'h80, 32'hDEAD_BEEF);
		for (i = 0; i < 512; i++) pop({1'b0, 32'(i)});
		rdc(8'h30, 32'h0000_0002);
		`CHK(atf_empty, 1'b1)
		// ram test: write three words with marker 1, read them back
		wr(8'h30, 32'h0000_0030);
		`CHK(fifo_ram_test_mode, 1'b1)
		wr(8'h30, 32'h0000_0038);
		for (i = 0; i < 3; i++) wr(8'h80, 32'hC0DE_0000 + 32'(i));
		rdc(8'h30, 32'h0000_00F2);
		wr(8'h30, 32'h0000_0038);
		for (i = 0; i < 3; i++) rdc(8'h80, 32'hC0DE_0000 + 32'(i));
		rdc(8'h30, 32'h0000_00F2);
		// expected marker 0 against stored 1 flags a mismatch
		wr(8'h30, 32'h0000_0028);
		rdc(8'h80, 32'hC0DE_0000);
		rdc(8'h30, 32'h0000_0066);
		wr(8'h30, 32'h0000_0000);
		`CHK(fifo_ram_test_mode, 1'b0)
		rdc(8'h30, 32'h0000_0002, 32'h0000_003F);
		summarize();
	end
endmodule // link_diag_phy_access_regs_bench
`default_nettype wire
